// ===== common/tpb_pkg.sv
// Package for the timer/PWM/buzzer unit: register offsets, fields, reset values.
// Assumes an AXI4-Lite master with 32-bit data; each register takes one aligned word.
package tpb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_COUNT = 4'h0;
    localparam logic [3:0] IDX_CTRL1 = 4'h1;
    localparam logic [3:0] IDX_CTRL2 = 4'h2;
    localparam logic [3:0] IDX_DUTY = 4'h3;
    localparam logic [3:0] IDX_PSCV = 4'h4;
    localparam logic [3:0] IDX_BUZZ = 4'h5;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
    localparam logic [3:0] IDX_IRQ_CLR = 4'h9;
    localparam logic [3:0] IDX_IRQ_EN = 4'hA;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 6;
    // Control register 1 fields
    localparam int C1_EN = 0;
    localparam int C1_RELOAD = 1;
    localparam int C1_ONESHOT = 2;
    localparam int C1_PWM_AL = 6;
    localparam int C1_PWM_OE = 7;
    // Control register 2 fields
    localparam int C2_PS_LSB = 0;
    localparam int C2_PS_DIS_N = 3;
    localparam int C2_EDGE = 4;
    localparam int C2_SRC = 5;
    // Buzzer control fields
    localparam int BZ_EN = 7;
    // Interrupt status bits
    localparam int IRQ_UNDERFLOW = 0;
    localparam int IRQ_N = 1;
    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [5:0] CTRL2_RST = 6'h3F;
    localparam logic [7:0] PSCV_RST = 8'hFF;
    localparam logic [3:0] BZ_FSEL_RST = 4'hF;
    localparam logic [7:0] COUNT_RST = 8'hFF;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [31:0] WO_READ_VAL = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       pwm_oe;
        logic       pwm_active_low;
        logic       one_shot_select;
        logic       reload_select;
        logic       timer_enable;
    } tpb_ctrl1_t;

    typedef struct packed {
        logic       count_source_select;
        logic       ext_count_edge_select;
        logic       prescale_disable_n;
        logic [2:0] prescale_rate_select;
    } tpb_ctrl2_t;

    typedef struct packed {
        logic       buzzer_enable;
        logic [3:0] buzzer_freq_select;
    } tpb_buzz_t;
endpackage : tpb_pkg

// ===== verilog/tpb_timer_unit.sv
// Timer unit: 8-bit down counter with prescaler, PWM and buzzer, AXI4-Lite registers.
// Assumes one clock aclk; ext_count_pin is asynchronous and is synchronised here.

// Functional notes
// - The prescaler disable bit is active high: 1 disables, 0 enables the prescaler.
// - External counting decrements on a falling pin edge when edge select is 1, rising when 0.
// - Source select 1 clocks the timer from the external pin, 0 from the instruction clock.
// - The PWM duty register is write-only and reads give no duty value.
// - PWM is inactive after enable until the count equals duty, then active until underflow.
// - The reload value sets the PWM period and the duty value sets the duty cycle.
// - The prescaler count view is read-only, shows the live count and resets to all ones.
// - Buzzer codes 0 to 7 use the prescaler output divided by 2 up to 256.
// - Buzzer codes 8 to 15 use timer count bits 0 to 7.
// - Buzzer control is write-only, its enable turns the buzzer on, frequency resets to 1111.
// - Reading the count gives the live count; writing loads reload and counter together.
// - One-shot stops at underflow; non-stop restarts from 0xFF or reload per the reload bit.
// - The prescaler rate field divides the timer clock from 1:2 at 000 to 1:256 at 111.
// - The PWM polarity bit makes the output active low when set.
module tpb_timer_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_count_pin,
    output logic pwm_output,
    output logic pwm_output_oe,
    output logic buzzer_output,
    output logic irq
);
    // Register state
    logic [7:0] count_r, count_nxt;
    logic [7:0] reload_r, reload_nxt;
    logic [7:0] duty_r, duty_nxt;
    logic [7:0] pscv_r, pscv_nxt;
    tpb_pkg::tpb_ctrl1_t ctrl1_r, ctrl1_nxt;
    tpb_pkg::tpb_ctrl2_t ctrl2_r, ctrl2_nxt;
    tpb_pkg::tpb_buzz_t buzz_r, buzz_nxt;
    logic [tpb_pkg::IRQ_N-1:0] irq_stat_r, irq_stat_nxt;
    logic [tpb_pkg::IRQ_N-1:0] irq_en_r, irq_en_nxt;
    logic stopped_r, stopped_nxt;
    logic pwm_act_r, pwm_act_nxt;
    logic pwm_r, pwm_nxt;
    logic [7:0] bz_div_r, bz_div_nxt;
    logic bz_r, bz_nxt;
    logic [2:0] pin_sync_r, pin_sync_nxt;

    // AXI state
    logic aw_got_r, aw_got_nxt;
    logic w_got_r, w_got_nxt;
    logic [3:0] aw_idx_r, aw_idx_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    logic wr_go;
    logic [3:0] rd_idx;
    logic [3:0] wr_idx;
    logic [7:0] wbyte;
    logic wr_lane0;
    logic ext_edge;
    logic timer_tick;
    logic ps_out;
    logic count_tick;
    logic underflow;
    logic bz_src_tick;
    logic [7:0] ps_mask;

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pwm_output = pwm_r;
    assign pwm_output_oe = ctrl1_r.pwm_oe;
    assign buzzer_output = bz_r;
    assign irq = |(irq_stat_r & irq_en_r);

    assign wr_idx = s_axi_awvalid && s_axi_awready ? s_axi_awaddr[tpb_pkg::ADDR_W-1:tpb_pkg::ADDR_LSB] : aw_idx_r;
    assign wbyte = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : wdata_r[7:0];
    // Lane strobe is kept with the data, since the master may change it before the address arrives
    assign wr_lane0 = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : wstrb0_r;
    assign wr_go = (aw_got_r || (s_axi_awvalid && s_axi_awready)) &&
                   (w_got_r || (s_axi_wvalid && s_axi_wready)) && !bvalid_r;
    assign rd_idx = s_axi_araddr[tpb_pkg::ADDR_W-1:tpb_pkg::ADDR_LSB];

    // Timer clock: edge of the twice-synchronised pin or every instruction clock
    assign ext_edge = ctrl2_r.ext_count_edge_select ? (pin_sync_r[2] && !pin_sync_r[1])
                                                      : (!pin_sync_r[2] && pin_sync_r[1]);
    assign timer_tick = ctrl2_r.count_source_select ? ext_edge : 1'b1;
    // Prescaler output pulses when its low bits wrap to zero under the rate mask
    always_comb begin
        ps_mask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i <= int'(ctrl2_r.prescale_rate_select)) begin
                ps_mask[i] = 1'b1;
            end
        end
    end
    assign ps_out = timer_tick && ((pscv_r & ps_mask) == tpb_pkg::COUNT_ZERO);
    // Disabled prescaler passes every timer clock straight to the counter
    assign count_tick = ctrl2_r.prescale_disable_n ? timer_tick : ps_out;
    assign underflow = ctrl1_r.timer_enable && !stopped_r && count_tick && count_r == tpb_pkg::COUNT_ZERO;

    // Buzzer divider taps the prescaler output; a bit toggles every 2^k pulses
    assign bz_src_tick = ps_out && ((bz_div_r & ((8'h01 << buzz_r.buzzer_freq_select[2:0]) - 8'h01)) ==
                         tpb_pkg::COUNT_ZERO);

    always_comb begin
        pin_sync_nxt = {pin_sync_r[1:0], ext_count_pin};
        count_nxt = count_r;
        reload_nxt = reload_r;
        duty_nxt = duty_r;
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        buzz_nxt = buzz_r;
        irq_en_nxt = irq_en_r;
        irq_stat_nxt = irq_stat_r;
        stopped_nxt = stopped_r;
        pwm_act_nxt = pwm_act_r;
        // Prescaler runs off the timer clock only when enabled
        pscv_nxt = (!ctrl2_r.prescale_disable_n && timer_tick) ? pscv_r - 8'h01 : pscv_r;
        bz_div_nxt = ps_out ? bz_div_r + 8'h01 : bz_div_r;

        if (ctrl1_r.timer_enable && !stopped_r && count_tick) begin
            if (count_r == tpb_pkg::COUNT_ZERO) begin
                pwm_act_nxt = 1'b0;
                if (ctrl1_r.one_shot_select) begin
                    stopped_nxt = 1'b1;
                end else if (ctrl1_r.reload_select) begin
                    count_nxt = reload_r;
                end else begin
                    count_nxt = tpb_pkg::COUNT_TOP;
                end
            end else begin
                count_nxt = count_r - 8'h01;
                if (count_r - 8'h01 == duty_r) begin
                    pwm_act_nxt = 1'b1;
                end
            end
        end
        if (!ctrl1_r.timer_enable) begin
            pwm_act_nxt = 1'b0;
            stopped_nxt = 1'b0;
        end

        if (wr_go && wr_lane0) begin
            case (wr_idx)
                tpb_pkg::IDX_COUNT: begin
                    reload_nxt = wbyte;
                    count_nxt = wbyte;
                    stopped_nxt = 1'b0;
                    pwm_act_nxt = (wbyte == duty_r);
                end
                tpb_pkg::IDX_CTRL1: ctrl1_nxt = {wbyte[tpb_pkg::C1_PWM_OE], wbyte[tpb_pkg::C1_PWM_AL],
                                                 wbyte[tpb_pkg::C1_ONESHOT], wbyte[tpb_pkg::C1_RELOAD],
                                                 wbyte[tpb_pkg::C1_EN]};
                tpb_pkg::IDX_CTRL2: ctrl2_nxt = wbyte[5:0];
                tpb_pkg::IDX_DUTY: duty_nxt = wbyte;
                tpb_pkg::IDX_BUZZ: buzz_nxt = {wbyte[tpb_pkg::BZ_EN], wbyte[3:0]};
                tpb_pkg::IDX_IRQ_CLR: irq_stat_nxt = irq_stat_r & ~wbyte[tpb_pkg::IRQ_N-1:0];
                tpb_pkg::IDX_IRQ_EN: irq_en_nxt = wbyte[tpb_pkg::IRQ_N-1:0];
                default: begin
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        if (underflow) begin
            irq_stat_nxt[tpb_pkg::IRQ_UNDERFLOW] = 1'b1;
        end

        pwm_nxt = (ctrl1_r.timer_enable && pwm_act_r) ^ ctrl1_r.pwm_active_low;

        if (!buzz_r.buzzer_enable) begin
            bz_nxt = 1'b0;
        end else if (buzz_r.buzzer_freq_select[3]) begin
            bz_nxt = count_r[buzz_r.buzzer_freq_select[2:0]];
        end else begin
            bz_nxt = bz_src_tick ? !bz_r : bz_r;
        end
    end

    // AXI handshake next state
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        aw_idx_nxt = aw_idx_r;
        wdata_nxt = wdata_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            aw_idx_nxt = s_axi_awaddr[tpb_pkg::ADDR_W-1:tpb_pkg::ADDR_LSB];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb0_nxt = s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            case (wr_idx)
                tpb_pkg::IDX_COUNT, tpb_pkg::IDX_CTRL1, tpb_pkg::IDX_CTRL2, tpb_pkg::IDX_DUTY,
                tpb_pkg::IDX_BUZZ, tpb_pkg::IDX_IRQ_CLR, tpb_pkg::IDX_IRQ_EN: bresp_nxt = tpb_pkg::RESP_OKAY;
                default: bresp_nxt = tpb_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = tpb_pkg::RESP_OKAY;
            case (rd_idx)
                tpb_pkg::IDX_COUNT: rdata_nxt = {24'h000000, count_r};
                tpb_pkg::IDX_CTRL1: rdata_nxt = {29'h0000000, ctrl1_r.one_shot_select,
                                                 ctrl1_r.reload_select, ctrl1_r.timer_enable};
                tpb_pkg::IDX_CTRL2: rdata_nxt = {26'h000000, ctrl2_r};
                tpb_pkg::IDX_DUTY: rdata_nxt = tpb_pkg::WO_READ_VAL;
                tpb_pkg::IDX_PSCV: rdata_nxt = {24'h000000, pscv_r};
                tpb_pkg::IDX_BUZZ: rdata_nxt = tpb_pkg::WO_READ_VAL;
                tpb_pkg::IDX_IRQ_STAT: rdata_nxt = {31'h0000000, irq_stat_r};
                tpb_pkg::IDX_IRQ_CLR: rdata_nxt = tpb_pkg::WO_READ_VAL;
                tpb_pkg::IDX_IRQ_EN: rdata_nxt = {31'h0000000, irq_en_r};
                default: begin
                    rdata_nxt = tpb_pkg::WO_READ_VAL;
                    rresp_nxt = tpb_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_r <= 3'h0;
            count_r <= tpb_pkg::COUNT_RST;
            reload_r <= tpb_pkg::COUNT_RST;
            duty_r <= tpb_pkg::DUTY_RST;
            pscv_r <= tpb_pkg::PSCV_RST;
            ctrl1_r <= tpb_pkg::CTRL1_RST[4:0];
            ctrl2_r <= tpb_pkg::CTRL2_RST;
            buzz_r <= {1'b0, tpb_pkg::BZ_FSEL_RST};
            irq_stat_r <= 1'h0;
            irq_en_r <= 1'h0;
            stopped_r <= 1'b0;
            pwm_act_r <= 1'b0;
            pwm_r <= 1'b0;
            wstrb0_r <= 1'b0;
            bz_div_r <= 8'h00;
            bz_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_idx_r <= 4'h0;
            wdata_r <= 32'h00000000;
            bvalid_r <= 1'b0;
            bresp_r <= tpb_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= tpb_pkg::RESP_OKAY;
        end else begin
            pin_sync_r <= pin_sync_nxt;
            count_r <= count_nxt;
            reload_r <= reload_nxt;
            duty_r <= duty_nxt;
            pscv_r <= pscv_nxt;
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            buzz_r <= buzz_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            stopped_r <= stopped_nxt;
            pwm_act_r <= pwm_act_nxt;
            pwm_r <= pwm_nxt;
            wstrb0_r <= wstrb0_nxt;
            bz_div_r <= bz_div_nxt;
            bz_r <= bz_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_idx_r <= aw_idx_nxt;
            wdata_r <= wdata_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
endmodule : tpb_timer_unit

// ===== sim/tpb_timer_unit_props.sv
// Checker for the timer unit: register bus timing, write-only reads, buzzer idle level.
// Assumes binding into tpb_timer_unit; sees only that module's ports.
module tpb_timer_unit_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic buzzer_output
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] wa_r;
    logic [5:0] ra_r;
    logic [7:0] wd_r;
    logic bz_on_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A write counts once its response shows, so split address and data phases are covered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bz_on_r <= 1'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
            if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
            if ($rose(s_axi_bvalid) && wa_r == 6'h14) bz_on_r <= wd_r[7];
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_resp_a: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("write response missing one cycle after both channels taken");
    rd_resp_a: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response missing one cycle after address taken");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while a read response is pending");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while a write response is pending");
    duty_read_a: assert property (s_axi_rvalid && ra_r == 6'h0C |-> s_axi_rdata == 32'h0)
        else $error("duty register read returned data");
    buzz_read_a: assert property (s_axi_rvalid && ra_r == 6'h14 |-> s_axi_rdata == 32'h0)
        else $error("buzzer control read returned data");
    bad_addr_a: assert property (s_axi_rvalid && ra_r == 6'h3C |-> s_axi_rresp == tpb_pkg::RESP_SLVERR)
        else $error("unmapped read not answered with slave error");
    read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    buzz_off_a: assert property (!bz_on_r && !$past(bz_on_r) |-> !buzzer_output)
        else $error("buzzer output high while buzzer disabled");
endmodule : tpb_timer_unit_props

bind tpb_timer_unit tpb_timer_unit_props u_props (.*);

// ===== sim/tpb_pin_model.sv
// External count source: moves the count pin to the requested level after dly+1 clocks.
// Assumes the bench sets the level; the pin stands still between requests.
module tpb_pin_model (
    input wire logic aclk,
    input wire logic lvl,
    input wire logic [3:0] dly,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r = 4'h0;
    initial pin = 1'h0;
    always @(posedge aclk) begin
        if (pin == lvl) begin
            cnt_r <= 4'h0;
        end else if (cnt_r >= dly) begin
            pin <= lvl;
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule : tpb_pin_model

// ===== sim/tb_top.sv
// Bench for the timer unit: register tasks over AXI4-Lite, pin source, output counters.
// Assumes the checker is bound from its own file.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [5:0] s_axi_awaddr = 6'h0;
    logic [5:0] s_axi_araddr = 6'h0;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rdv, rsp, a;
    logic ext_count_pin, pwm_output, pwm_output_oe, buzzer_output, irq;
    logic pin_lvl = 1'h0;
    logic [3:0] pin_dly = 4'h0;
    int err_total = 0;
    int n_checks = 0;
    int mx, t, i, k;
    always #2 aclk = ~aclk;
    tpb_timer_unit DUT (.*);
    tpb_pin_model u_pin (.aclk(aclk), .lvl(pin_lvl), .dly(pin_dly), .pin(ext_count_pin));
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task near(input string nm, input int seen, input int exp);
        chk(nm, 32'(seen), (seen >= exp - 1 && seen <= exp + 1) ? 32'(seen) : 32'(exp));
    endtask : near
    task wr(input logic [5:0] ad, input logic [7:0] d);
        int j;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (j = 0; j < 50; j++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        rsp = {30'h0, s_axi_bresp};
        s_axi_bready <= 1'h0;
        if (j == 50) begin
            err_total++;
            conclude();
        end
    endtask : wr
    task rd(input logic [5:0] ad);
        int j;
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (j = 0; j < 50; j++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        rdv = s_axi_rdata;
        rsp = {30'h0, s_axi_rresp};
        s_axi_rready <= 1'h0;
        if (j == 50) begin
            err_total++;
            conclude();
        end
    endtask : rd
    // Fixed wait covers the model delay plus the three-clock pin synchroniser
    task pstep(input logic l, input logic [3:0] d, input logic [31:0] exp);
        @(posedge aclk);
        pin_lvl <= l;
        pin_dly <= d;
        repeat (12) @(posedge aclk);
        rd(6'h00);
        chk("count after pin edge", rdv, exp);
    endtask : pstep
    task settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle
    task tog(input int win, output int n, input bit hi);
        logic p;
        repeat (20) @(posedge aclk);
        p = hi ? pwm_output : buzzer_output;
        n = 0;
        repeat (win) begin
            @(posedge aclk);
            if (hi && pwm_output === 1'h1) n++;
            if (!hi && buzzer_output !== p) n++;
            p = buzzer_output;
        end
    endtask : tog
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd(6'h00); chk("count reset", rdv, 32'hFF);
        chk("read resp", rsp, 32'h0);
        rd(6'h10); chk("prescaler reset", rdv, 32'hFF);
        rd(6'h0C); chk("duty read", rdv, 32'h0);
        rd(6'h14); chk("buzzer read", rdv, 32'h0);
        rd(6'h3C); chk("unmapped resp", rsp, 32'h2);
        wr(6'h3C, 8'h00);
        chk("unmapped write resp", rsp, 32'h2);
        wr(6'h10, 8'h12); rd(6'h10); chk("prescaler read only", rdv, 32'hFF);
        wr(6'h00, 8'h20); rd(6'h00); chk("count write", rdv, 32'h20);
        wr(6'h08, 8'h28);
        chk("write resp", rsp, 32'h0);
        wr(6'h04, 8'h01);
        pstep(1'h1, 4'h0, 32'h1F);
        pstep(1'h0, 4'h0, 32'h1F);
        wr(6'h08, 8'h38);
        pstep(1'h1, 4'h3, 32'h1F);
        pstep(1'h0, 4'h3, 32'h1E);
        wr(6'h08, 8'h18); rd(6'h00); a = rdv; rd(6'h00); chk("internal clock", 32'(a != rdv), 32'h1);
        wr(6'h04, 8'h00); wr(6'h24, 8'h01); rd(6'h20); chk("status cleared", rdv, 32'h0);
        wr(6'h28, 8'h01); wr(6'h08, 8'h08); wr(6'h00, 8'h10); wr(6'h04, 8'h05);
        for (i = 0; i < 100 && irq !== 1'h1; i++) @(posedge aclk);
        chk("underflow irq", irq, 32'h1);
        rd(6'h00); a = rdv; rd(6'h00); chk("one shot stopped", rdv, a);
        wr(6'h28, 8'h00); settle(); chk("irq masked", irq, 32'h0);
        wr(6'h28, 8'h01); settle(); chk("irq unmasked", irq, 32'h1);
        wr(6'h24, 8'h01); settle(); chk("irq cleared", irq, 32'h0);
        for (k = 0; k < 2; k++) begin
            wr(6'h00, 8'h10); wr(6'h04, k ? 8'h01 : 8'h03); mx = 0;
            for (i = 0; i < 20; i++) begin
                rd(6'h00);
                if (rdv > mx) mx = rdv;
            end
            chk("reload bound", 32'(mx > 16), 32'(k));
        end
        wr(6'h00, 8'h10); wr(6'h04, 8'h83);
        for (k = 0; k < 2; k++) begin
            wr(6'h0C, k ? 8'h08 : 8'h02);
            tog(136, t, 1'b1); near("pwm active cycles", t, k ? 72 : 24);
        end
        wr(6'h04, 8'hC3); tog(136, t, 1'b1); near("pwm active low", t, 64);
        chk("pwm enable", pwm_output_oe, 32'h1);
        wr(6'h04, 8'h01); tog(256, t, 1'b0); chk("buzzer idle", 32'(t), 32'h0);
        chk("pwm disable", pwm_output_oe, 32'h0);
        chk("buzzer low", buzzer_output, 32'h0);
        wr(6'h08, 8'h08);
        rd(6'h10);
        a = rdv;
        rd(6'h10);
        chk("prescaler held", rdv, a);
        for (k = 0; k < 8; k++) begin
            wr(6'h14, 8'(8'h88 + k)); tog(256, t, 1'b0); near("timer bit source", t, 1 << (8 - k));
        end
        for (k = 0; k < 8; k++) begin
            wr(6'h08, 8'(8'h08 + k)); wr(6'h08, 8'(k));
            wr(6'h14, 8'h88); tog(512, t, 1'b0); near("prescale rate", t, 1 << (8 - k));
        end
        wr(6'h08, 8'h08); wr(6'h08, 8'h00);
        rd(6'h10); a = rdv; rd(6'h10); chk("prescaler live", 32'(a != rdv), 32'h1);
        for (k = 0; k < 8; k++) begin
            wr(6'h14, 8'(8'h80 + k)); tog(512, t, 1'b0); near("prescaler divide", t, 1 << (8 - k));
        end
        wr(6'h14, 8'h0F); tog(256, t, 1'b0); chk("buzzer off", 32'(t), 32'h0);
        chk("buzzer off low", buzzer_output, 32'h0);
        conclude();
    end
endmodule : tb_top
